// ### rtl/i2cms_sequencer.sv
// Purpose: Master-side sequencer of a two-wire serial port: start, restart,
//          stop, acknowledge sequences and byte transmission.
// Assumes: Lines are open-drain; the outside resolves the wire levels.
// Notes:   Pin inputs pass three synchroniser flip-flops and a filter flip-flop before the engine sees them.

// Contract
// - Restart: pull clock low, then start timing
// - Restart phases: data high, clock high, data low
// - Restart end: clear request, data held low
// - Start seen at once, interrupt after timeout
// - Restart ignored while engine busy
// - Restart collision on data low or clock fall
// - Buffer write sets full flag, starts transmit
// - Bit: clock low one period, high one
// - Any byte sent most significant first
// - Eighth falling edge: clear full, release data
// - Ninth clock samples acknowledge into status
// - After ninth: interrupt, suspend with clock low
// - Write during transmit, ack or stop sets collision, byte dropped
// - Start completion raises interrupt, then waits
// - Stop or restart completion raises interrupt
// - Ack sequence: clock low, drive ack value
// - Ack timing: period, release, wait, period
// - Ack end: clear request, generator off, idle
// - Stop: data low, period, clock, data
// - Stop seen, then clear request and interrupt
// - Data low while driving high is collision
// - Lines only pulled low or released
// - Whole bytes plus acknowledge, MSB first
module i2cms_sequencer
  import i2cms_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  // Control requests and configuration.
  input  wire logic                    port_enable_in,
  input  wire logic                    start_request_set_in,
  input  wire logic                    restart_request_set_in,
  input  wire logic                    stop_request_set_in,
  input  wire logic                    ack_sequence_request_set_in,
  input  wire logic                    ack_value_select_in,
  input  wire logic [I2CMS_BAUD_W-1:0] baud_reload_in,
  input  wire logic                    write_collision_clear_in,
  input  wire logic                    port_irq_clear_in,
  // Transfer buffer write stream.
  input  wire logic [I2CMS_BYTE_W-1:0] tx_data_in,
  input  wire logic                    tx_valid_in,
  output logic                         tx_ready_out,
  // Status.
  output logic                         start_request_out,
  output logic                         restart_request_out,
  output logic                         stop_request_out,
  output logic                         ack_sequence_request_out,
  output logic                         buffer_full_flag_out,
  output logic                         write_collision_flag_out,
  output logic                         ack_received_status_out,
  output logic                         port_irq_flag_out,
  output logic                         start_seen_out,
  output logic                         stop_seen_out,
  output logic                         bus_collision_out,
  // Open-drain pins.
  input  wire logic                    serial_clock_pin_in,
  output logic                         serial_clock_pin_out,
  output logic                         serial_clock_pin_oe_out,
  input  wire logic                    serial_data_pin_in,
  output logic                         serial_data_pin_out,
  output logic                         serial_data_pin_oe_out
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [I2CMS_SYNC_N-1:0] scl_sync_q, sda_sync_q;
  logic                    scl_f_q, sda_f_q, scl_p_q, sda_p_q;

  // Three stages; a level counts once the last two stages agree.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_sync_q <= '1;
      sda_sync_q <= '1;
      scl_f_q    <= 1'b1;
      sda_f_q    <= 1'b1;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], serial_clock_pin_in};
      sda_sync_q <= {sda_sync_q[1:0], serial_data_pin_in};
      scl_p_q    <= scl_f_q;
      sda_p_q    <= sda_f_q;
      if (scl_sync_q[1] == scl_sync_q[2]) scl_f_q <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2]) sda_f_q <= sda_sync_q[2];
    end
  end

  // ****************************************************************
  // Two-entry transfer buffer
  // ****************************************************************
  logic [I2CMS_BYTE_W-1:0] buf_q [I2CMS_BUF_DEPTH];
  logic [I2CMS_PTR_W-1:0]  wr_ptr_q, rd_ptr_q;
  logic [I2CMS_CNT_W-1:0]  cnt_q, cnt_d;
  logic                    push, pop, head_valid, take_byte, drop_byte;
  i2cms_state_t            state_q;

  // Bytes are taken when the engine may start one and dropped when it is
  // busy; in start and restart phases the drain stalls and the buffer fills.
  assign head_valid = (cnt_q != '0);
  assign push       = tx_valid_in && tx_ready_out;
  assign take_byte  = head_valid && (state_q == I2CMS_IDLE || state_q == I2CMS_HOLD);
  assign drop_byte  = head_valid && (state_q inside {I2CMS_TX_LOW, I2CMS_TX_REL,
                      I2CMS_TX_HIGH, I2CMS_AK_LOW, I2CMS_AK_REL, I2CMS_AK_HIGH,
                      I2CMS_SP_SDALO, I2CMS_SP_WAIT, I2CMS_SP_SCLHI, I2CMS_SP_SDAHI,
                      I2CMS_SP_END});
  assign pop        = take_byte || drop_byte;
  assign cnt_d      = cnt_q + I2CMS_CNT_W'(push) - I2CMS_CNT_W'(pop);

  // Buffer storage, pointers and the registered ready.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_q     <= '0;
      rd_ptr_q     <= '0;
      cnt_q        <= '0;
      tx_ready_out <= 1'b0;
      buf_q[0]     <= '0;
      buf_q[1]     <= '0;
    end else begin
      if (push) begin
        buf_q[wr_ptr_q] <= tx_data_in;
        wr_ptr_q        <= wr_ptr_q + 1'b1;
      end
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      cnt_q        <= cnt_d;
      tx_ready_out <= (cnt_d != I2CMS_BUF_FULL);
    end
  end

  // ****************************************************************
  // Sequencer, baud generator and flags
  // ****************************************************************
  logic [I2CMS_BAUD_W-1:0] brg_q;
  logic                    brg_run_q, tick;
  logic [I2CMS_BIT_W-1:0]  bit_q;
  logic [I2CMS_BYTE_W-1:0] shift_q;
  logic                    bf_q;

  assign tick = brg_run_q && (brg_q == '0);

  // Main engine; a sticky flag set in the same cycle as its clear stays set.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= I2CMS_IDLE;
      brg_q <= I2CMS_BAUD_RST;
      brg_run_q <= 1'b0;
      bit_q <= '0;
      shift_q <= '0;
      bf_q <= 1'b0;
      start_request_out <= 1'b0;
      restart_request_out <= 1'b0;
      stop_request_out <= 1'b0;
      ack_sequence_request_out <= 1'b0;
      write_collision_flag_out <= 1'b0;
      ack_received_status_out <= 1'b0;
      port_irq_flag_out <= 1'b0;
      start_seen_out <= 1'b0;
      stop_seen_out <= 1'b0;
      bus_collision_out <= 1'b0;
      serial_clock_pin_oe_out <= 1'b0;
      serial_data_pin_oe_out <= 1'b0;
    end else if (!port_enable_in) begin
      state_q <= I2CMS_IDLE;
      brg_run_q <= 1'b0;
      bf_q <= 1'b0;
      start_request_out <= 1'b0;
      restart_request_out <= 1'b0;
      stop_request_out <= 1'b0;
      ack_sequence_request_out <= 1'b0;
      serial_clock_pin_oe_out <= 1'b0;
      serial_data_pin_oe_out <= 1'b0;
    end else begin
      // Baud countdown of the reload value.
      if (brg_run_q && brg_q != '0) brg_q <= brg_q - 1'b1;
      // Sticky flags cleared by software.
      if (write_collision_clear_in) write_collision_flag_out <= 1'b0;
      if (port_irq_clear_in) port_irq_flag_out <= 1'b0;
      if (drop_byte) write_collision_flag_out <= 1'b1;
      // Start and stop conditions watched on the lines.
      if (scl_f_q && scl_p_q && sda_p_q && !sda_f_q) begin
        start_seen_out <= 1'b1;
        stop_seen_out  <= 1'b0;
      end
      if (scl_f_q && scl_p_q && !sda_p_q && sda_f_q) begin
        stop_seen_out  <= 1'b1;
        start_seen_out <= 1'b0;
      end
      unique case (state_q)
        I2CMS_IDLE, I2CMS_HOLD: begin
          if (take_byte) begin
            shift_q <= buf_q[rd_ptr_q];
            bf_q    <= 1'b1;
            bit_q   <= '0;
            serial_clock_pin_oe_out <= 1'b1;
            serial_data_pin_oe_out  <= ~buf_q[rd_ptr_q][I2CMS_BYTE_W-1];
            brg_q <= baud_reload_in;
            brg_run_q <= 1'b1;
            state_q <= I2CMS_TX_LOW;
          end else if (start_request_set_in && state_q == I2CMS_IDLE) begin
            start_request_out <= 1'b1;
            serial_data_pin_oe_out <= 1'b1;
            brg_q <= baud_reload_in;
            brg_run_q <= 1'b1;
            state_q <= I2CMS_ST_SDALO;
          end else if (restart_request_set_in) begin
            restart_request_out <= 1'b1;
            serial_clock_pin_oe_out <= 1'b1;
            state_q <= I2CMS_RS_SCLLO;
          end else if (stop_request_set_in) begin
            stop_request_out <= 1'b1;
            serial_data_pin_oe_out <= 1'b1;
            state_q <= I2CMS_SP_SDALO;
          end else if (ack_sequence_request_set_in) begin
            ack_sequence_request_out <= 1'b1;
            serial_clock_pin_oe_out <= 1'b1;
            serial_data_pin_oe_out  <= ~ack_value_select_in;
            brg_q <= baud_reload_in;
            brg_run_q <= 1'b1;
            state_q <= I2CMS_AK_LOW;
          end
        end
        I2CMS_ST_SDALO: if (tick) begin
          serial_clock_pin_oe_out <= 1'b1;
          start_request_out <= 1'b0;
          port_irq_flag_out <= 1'b1;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_HOLD;
        end
        I2CMS_RS_SCLLO: if (!scl_f_q) begin
          serial_data_pin_oe_out <= 1'b0;
          brg_q <= baud_reload_in;
          brg_run_q <= 1'b1;
          state_q <= I2CMS_RS_SDAHI;
        end
        I2CMS_RS_SDAHI: if (tick && sda_f_q) begin
          serial_clock_pin_oe_out <= 1'b0;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_RS_SCLREL;
        end
        I2CMS_RS_SCLREL: if (scl_f_q) begin
          if (!sda_f_q) begin
            bus_collision_out <= 1'b1;
            restart_request_out <= 1'b0;
            state_q <= I2CMS_IDLE;
          end else begin
            brg_q <= baud_reload_in;
            brg_run_q <= 1'b1;
            state_q <= I2CMS_RS_HIGH;
          end
        end
        I2CMS_RS_HIGH: begin
          if (!scl_f_q || !sda_f_q) begin
            bus_collision_out <= 1'b1;
            restart_request_out <= 1'b0;
            brg_run_q <= 1'b0;
            state_q <= I2CMS_IDLE;
          end else if (tick) begin
            serial_data_pin_oe_out <= 1'b1;
            brg_q <= baud_reload_in;
            state_q <= I2CMS_RS_SDALO;
          end
        end
        I2CMS_RS_SDALO: if (tick) begin
          serial_clock_pin_oe_out <= 1'b1;
          restart_request_out <= 1'b0;
          port_irq_flag_out <= 1'b1;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_HOLD;
        end
        I2CMS_TX_LOW: if (tick) begin
          serial_clock_pin_oe_out <= 1'b0;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_TX_REL;
        end
        I2CMS_TX_REL: if (scl_f_q) begin
          if (bit_q == I2CMS_ACK_BIT) ack_received_status_out <= sda_f_q;
          brg_q <= baud_reload_in;
          brg_run_q <= 1'b1;
          state_q <= I2CMS_TX_HIGH;
        end
        I2CMS_TX_HIGH: begin
          if (bit_q != I2CMS_ACK_BIT && !serial_data_pin_oe_out && !sda_f_q) begin
            bus_collision_out <= 1'b1;
          end
          if (tick) begin
            serial_clock_pin_oe_out <= 1'b1;
            if (bit_q == I2CMS_ACK_BIT) begin
              port_irq_flag_out <= 1'b1;
              brg_run_q <= 1'b0;
              state_q <= I2CMS_HOLD;
            end else begin
              if (bit_q == I2CMS_LAST_DATA) begin
                bf_q <= 1'b0;
                serial_data_pin_oe_out <= 1'b0;
              end else begin
                serial_data_pin_oe_out <= ~shift_q[I2CMS_BYTE_W-2];
              end
              shift_q <= {shift_q[I2CMS_BYTE_W-2:0], 1'b0};
              bit_q <= bit_q + 1'b1;
              brg_q <= baud_reload_in;
              state_q <= I2CMS_TX_LOW;
            end
          end
        end
        I2CMS_AK_LOW: if (tick) begin
          serial_clock_pin_oe_out <= 1'b0;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_AK_REL;
        end
        I2CMS_AK_REL: if (scl_f_q) begin
          brg_q <= baud_reload_in;
          brg_run_q <= 1'b1;
          state_q <= I2CMS_AK_HIGH;
        end
        I2CMS_AK_HIGH: if (tick) begin
          serial_clock_pin_oe_out <= 1'b1;
          ack_sequence_request_out <= 1'b0;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_IDLE;
        end
        I2CMS_SP_SDALO: if (!sda_f_q) begin
          brg_q <= baud_reload_in;
          brg_run_q <= 1'b1;
          state_q <= I2CMS_SP_WAIT;
        end
        I2CMS_SP_WAIT: if (tick) begin
          serial_clock_pin_oe_out <= 1'b0;
          brg_q <= baud_reload_in;
          state_q <= I2CMS_SP_SCLHI;
        end
        I2CMS_SP_SCLHI: if (tick) begin
          serial_data_pin_oe_out <= 1'b0;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_SP_SDAHI;
        end
        I2CMS_SP_SDAHI: if (sda_f_q && scl_f_q) begin
          brg_q <= baud_reload_in;
          brg_run_q <= 1'b1;
          state_q <= I2CMS_SP_END;
        end
        I2CMS_SP_END: if (tick) begin
          stop_request_out <= 1'b0;
          port_irq_flag_out <= 1'b1;
          brg_run_q <= 1'b0;
          state_q <= I2CMS_IDLE;
        end
      endcase
    end
  end

  // Lines are only ever pulled low; the data level is a constant zero.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_clock_pin_out <= 1'b0;
      serial_data_pin_out  <= 1'b0;
      buffer_full_flag_out <= 1'b0;
    end else begin
      serial_clock_pin_out <= 1'b0;
      serial_data_pin_out  <= 1'b0;
      buffer_full_flag_out <= bf_q;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in || !port_enable_in);

  sequence rs_last_phase;
    state_q == I2CMS_RS_SDALO && tick;
  endsequence

  // Suspended with nothing pending: a buffer write or a request may end it.
  sequence hold_quiet;
    state_q == I2CMS_HOLD && !head_valid && !restart_request_set_in &&
      !stop_request_set_in && !ack_sequence_request_set_in;
  endsequence

  AST_RS_END: assert property (rs_last_phase |=> !restart_request_out &&
    serial_clock_pin_oe_out && serial_data_pin_oe_out && port_irq_flag_out)
    else $error("restart end wrong");
  AST_RS_IGNORE: assert property ((restart_request_set_in && !restart_request_out &&
    !(state_q inside {I2CMS_IDLE, I2CMS_HOLD})) |=> !restart_request_out)
    else $error("restart taken while busy");
  AST_BF_SET: assert property (take_byte |=> bf_q && state_q == I2CMS_TX_LOW)
    else $error("buffer write did not start transmit");
  AST_WRITE_COLLISION_FLAG: assert property (drop_byte |=> write_collision_flag_out)
    else $error("collision flag not set");
  AST_EIGHTH: assert property ((state_q == I2CMS_TX_HIGH && tick &&
    bit_q == I2CMS_LAST_DATA) |=> !bf_q && !serial_data_pin_oe_out)
    else $error("eighth edge did not release data");
  AST_ACK_RECEIVED_STATUS: assert property ((state_q == I2CMS_TX_REL && scl_f_q &&
    bit_q == I2CMS_ACK_BIT) |=> ack_received_status_out == $past(sda_f_q))
    else $error("acknowledge status wrong");
  AST_SUSPEND: assert property ((state_q == I2CMS_TX_HIGH && tick &&
    bit_q == I2CMS_ACK_BIT) |=> port_irq_flag_out && !brg_run_q &&
    serial_clock_pin_oe_out && state_q == I2CMS_HOLD)
    else $error("suspend after ninth clock wrong");
  AST_HOLD_STILL: assert property (hold_quiet |=> state_q == I2CMS_HOLD &&
    !brg_run_q && serial_clock_pin_oe_out && $stable(serial_data_pin_oe_out))
    else $error("held clock or data moved");
  AST_ACK_END: assert property ((state_q == I2CMS_AK_HIGH && tick) |=>
    !ack_sequence_request_out && !brg_run_q && state_q == I2CMS_IDLE)
    else $error("ack sequence end wrong");
  AST_STOP_END: assert property ((state_q == I2CMS_SP_END && tick) |=>
    !stop_request_out && port_irq_flag_out)
    else $error("stop end wrong");
  AST_OPEN_DRAIN: assert property (!serial_clock_pin_out && !serial_data_pin_out)
    else $error("line driven high");
  AST_RELOAD: assert property ((state_q == I2CMS_SP_SDALO && !sda_f_q) |=>
    brg_run_q && brg_q == $past(baud_reload_in))
    else $error("baud generator not loaded");

endmodule : i2cms_sequencer

// ### rtl/i2cms_pkg.sv
// Purpose: Shared constants and types of the two-wire master sequencer.
// Assumes: One system clock; baud period set by a reload value.
// Notes:   Shared widths, bit indices, buffer limits and the baud reset value live here.
package i2cms_pkg;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned I2CMS_BYTE_W    = 8;
  localparam int unsigned I2CMS_BAUD_W    = 8;
  localparam int unsigned I2CMS_BIT_W     = 4;
  localparam int unsigned I2CMS_BUF_DEPTH = 2;
  localparam int unsigned I2CMS_PTR_W     = 1;
  localparam int unsigned I2CMS_CNT_W     = 2;
  localparam int unsigned I2CMS_SYNC_N    = 3;
  localparam logic [3:0]  I2CMS_LAST_DATA = 4'h7;
  localparam logic [3:0]  I2CMS_ACK_BIT   = 4'h8;
  localparam logic [1:0]  I2CMS_BUF_FULL  = 2'h2;
  localparam logic [7:0]  I2CMS_BAUD_RST  = 8'h00;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [4:0] {
    I2CMS_IDLE, I2CMS_HOLD,
    I2CMS_ST_SDALO,
    I2CMS_RS_SCLLO, I2CMS_RS_SDAHI, I2CMS_RS_SCLREL, I2CMS_RS_HIGH, I2CMS_RS_SDALO,
    I2CMS_TX_LOW, I2CMS_TX_REL, I2CMS_TX_HIGH,
    I2CMS_AK_LOW, I2CMS_AK_REL, I2CMS_AK_HIGH,
    I2CMS_SP_SDALO, I2CMS_SP_WAIT, I2CMS_SP_SCLHI, I2CMS_SP_SDAHI, I2CMS_SP_END
  } i2cms_state_t;

endpackage : i2cms_pkg

// ### testbench/i2cms_slave_model.sv
// Purpose: Behavioural slave on the two-wire bus for the sequencer bench.
// Assumes: Wire levels come in already resolved with pull-ups.
// Notes:   Acknowledges each byte only while ack_en_in is high.
module i2cms_slave_model (
  // Resolved wire levels.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  // Control and capture.
  input  wire logic       ack_en_in,
  output logic            sda_oe_out,
  output logic [7:0]      byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  initial begin
    cnt_q      = 4'h0;
    sh_q       = 8'h00;
    sda_oe_out = 1'b0;
    byte_out   = 8'h00;
  end
  // A start condition realigns the bit count.
  always @(negedge sda_in) begin
    if (scl_in) cnt_q <= 4'h0;
  end
  // Data bits are taken on the rising clock edge, MSB first.
  always @(posedge scl_in) begin
    if (cnt_q < 4'h8) sh_q <= {sh_q[6:0], sda_in};
    cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
  end
  // After the eighth falling edge the slave answers, then lets go.
  always @(negedge scl_in) begin
    if (cnt_q == 4'h8) begin
      byte_out   <= sh_q;
      sda_oe_out <= ack_en_in;
    end else begin
      sda_oe_out <= 1'b0;
    end
  end
endmodule // i2cms_slave_model

// ### testbench/i2cms_sequencer_bench.sv
// Purpose: Self-checking bench of the two-wire master sequencer.
// Assumes: Open-drain wires with pull-ups; reload of 3, a baud period of 4 clocks.
// Notes:   Inputs change on the falling clock edge.
module i2cms_sequencer_bench;
  import i2cms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rstn_in, en, st, rs, sp, ak, akv, wclr, iclr, vld, ack_en;
  logic [7:0] dat, sbyte;
  logic rdy, st_q, rs_q, sp_q, ak_q, bf, write_collision_flag, akst, irq, sseen, pseen, bcol;
  logic scl_o, scl_oe, sda_o, sda_oe, s_oe, scl_w, sda_w, hold_lo;
  int   fail_count, tests_run, n;
  // ****************************************************************
  // Wires, design and slave
  // ****************************************************************
  // Pull-ups: an enabled driver puts its level on the line; a holder pulls data low.
  assign scl_w = scl_oe ? scl_o : 1'b1;
  assign sda_w = (s_oe | hold_lo) ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  i2cms_sequencer DUT (.clk_in(clk_in), .rstn_in(rstn_in), .port_enable_in(en),
    .start_request_set_in(st), .restart_request_set_in(rs), .stop_request_set_in(sp),
    .ack_sequence_request_set_in(ak), .ack_value_select_in(akv), .baud_reload_in(8'h03),
    .write_collision_clear_in(wclr), .port_irq_clear_in(iclr), .tx_data_in(dat),
    .tx_valid_in(vld), .tx_ready_out(rdy), .start_request_out(st_q),
    .restart_request_out(rs_q), .stop_request_out(sp_q), .ack_sequence_request_out(ak_q),
    .buffer_full_flag_out(bf), .write_collision_flag_out(write_collision_flag),
    .ack_received_status_out(akst), .port_irq_flag_out(irq), .start_seen_out(sseen),
    .stop_seen_out(pseen), .bus_collision_out(bcol), .serial_clock_pin_in(scl_w),
    .serial_clock_pin_out(scl_o), .serial_clock_pin_oe_out(scl_oe),
    .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_o),
    .serial_data_pin_oe_out(sda_oe));
  i2cms_slave_model SLV (.scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en),
    .sda_oe_out(s_oe), .byte_out(sbyte));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Ends the run with the counts and the verdict.
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Compares one flag.
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Compares one byte.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pulses one request: 0 start, 1 restart, 2 stop, 3 ack sequence.
  task automatic req(input int k);
    @(negedge clk_in);
    case (k)
      0: st = 1'b1;
      1: rs = 1'b1;
      2: sp = 1'b1;
      default: ak = 1'b1;
    endcase
    @(negedge clk_in);
    {st, rs, sp, ak} = 4'h0;
  endtask
  // Hands one byte to the buffer once it is ready.
  task automatic send(input logic [7:0] b);
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    dat = b;
    vld = 1'b1;
    @(negedge clk_in);
    vld = 1'b0;
  endtask
  // Waits for the interrupt flag under a bound, then clears it.
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    chk_bit(irq, 1'b1);
    iclr = 1'b1;
    @(negedge clk_in);
    iclr = 1'b0;
    @(negedge clk_in);
  endtask
  // Sends one byte and checks capture and acknowledge status.
  task automatic byte_case(input logic [7:0] b, input logic a);
    ack_en = a;
    send(b);
    repeat (4) @(negedge clk_in);
    chk_bit(bf, 1'b1);
    req(1);
    chk_bit(rs_q, 1'b0);
    wait_irq();
    chk_byte(sbyte, b);
    chk_bit(akst, ~a);
    chk_bit(bf, 1'b0);
    chk_bit(scl_oe, 1'b1);
  endtask
  // ****************************************************************
  // Clock, watchdog and sequence
  // ****************************************************************
  // Free running system clock.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #(40 * 30000);
    fail_count++;
    close_out();
  end
  // Main test sequence.
  initial begin
    {rstn_in, st, rs, sp, ak, akv, wclr, iclr, vld, ack_en} = 10'h000;
    en = 1'b1;
    hold_lo = 1'b0;
    dat = 8'h00;
    fail_count = 0;
    tests_run = 0;
    repeat (16) @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    req(0);
    wait_irq();
    chk_bit(st_q, 1'b0);
    chk_bit(sseen, 1'b1);
    byte_case(8'ha5, 1'b1);
    byte_case(8'h5a, 1'b0);
    ack_en = 1'b1;
    send(8'h3c);
    repeat (20) @(negedge clk_in);
    send(8'h99);
    repeat (4) @(negedge clk_in);
    chk_bit(write_collision_flag, 1'b1);
    wait_irq();
    chk_byte(sbyte, 8'h3c);
    wclr = 1'b1;
    @(negedge clk_in);
    wclr = 1'b0;
    @(negedge clk_in);
    chk_bit(write_collision_flag, 1'b0);
    akv = 1'b0;
    req(3);
    n = 0;
    while (scl_w !== 1'b1 && n < 500) begin
      @(negedge clk_in);
      n++;
    end
    chk_bit(sda_oe, 1'b1);
    n = 0;
    while (ak_q !== 1'b0 && n < 500) begin
      @(negedge clk_in);
      n++;
    end
    chk_bit(ak_q, 1'b0);
    req(1);
    wait_irq();
    chk_bit(rs_q, 1'b0);
    chk_bit(sda_oe, 1'b1);
    chk_bit(sseen, 1'b1);
    chk_bit(bcol, 1'b0);
    req(2);
    wait_irq();
    chk_bit(sp_q, 1'b0);
    chk_bit(pseen, 1'b1);
    chk_bit(scl_w & sda_w, 1'b1);
    chk_bit(bcol, 1'b0);
    chk_bit(sseen, 1'b0);
    chk_bit(scl_o | sda_o, 1'b0);
    // Another party holds data low while a one goes out.
    hold_lo = 1'b1;
    send(8'h80);
    wait_irq();
    chk_bit(bcol, 1'b1);
    hold_lo = 1'b0;
    // Reset in mid-run clears the sticky collision and frees the lines.
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    chk_bit(bcol, 1'b0);
    chk_bit(scl_oe | sda_oe, 1'b0);
    chk_bit(rdy, 1'b0);
    @(negedge clk_in);
    chk_bit(rdy, 1'b1);
    req(0);
    wait_irq();
    chk_bit(st_q, 1'b0);
    close_out();
  end
endmodule // i2cms_sequencer_bench
